// File: dcf_fifo.sv
// fifo top: write/read ports, programmable offsets and status flags
//
// Contract
// RQ1 - reset returns both pointers to start
// RQ2 - reset: full/half/almost-full high, others low
// RQ3 - reset zeroes output, loads default offsets
// RQ4 - controller resets before first write
// RQ5 - enabled, loaded, not full: store word
// RQ6 - full flag low blocks writes until read
// RQ7 - full after exactly depth writes
// RQ8 - enabled, loaded, not empty: word to output
// RQ9 - read disabled: output register holds value
// RQ10 - reader requests every word, no fall-through
// RQ11 - empty flag low blocks reads until write
// RQ12 - output enable low drives data bus
// RQ13 - load writes offsets empty, full, empty
// RQ14 - offset write sequence kept across load
// RQ15 - load low, write disabled: nothing happens
// RQ16 - load reads offsets, own sequence pointer
// RQ17 - controllers avoid simultaneous offset read/write
// RQ18 - unused offset bits programmed as zero
// RQ19 - almost-full at depth minus full offset
// RQ20 - almost-full set on write, cleared read
// RQ21 - almost-empty while count within empty offset
// RQ22 - almost-empty set on read, cleared write
// RQ23 - board grounds chain pins for single use
// RQ24 - half-full beyond half depth, single mode
// RQ25 - pointers cross domains safely; the code runs on one clock, so no pointer crosses a domain
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo #(
  parameter int unsigned DEPTH = dcf_pkg::DCF_DEPTH_DEF,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // writer port
  input  wire dcf_pkg::dcf_wr_port_s wr_port,
  input  wire logic                  offset_load_n,
  // reader port
  input  wire dcf_pkg::dcf_rd_port_s rd_port,
  output logic [17:0]                read_data,
  output logic                       read_data_oe,
  // status flags
  output dcf_pkg::dcf_flags_s        flags,
  // chain pins
  input  wire logic                  first_in_chain_n,
  input  wire logic                  write_chain_in_n,
  input  wire logic                  read_chain_in_n,
  output logic                       write_chain_out_n,
  output logic                       read_chain_out_n
);
  import dcf_pkg::*;

  // widths of pointers, counts and threshold sums
  localparam int unsigned PW = AW + 1;
  localparam int unsigned SW = DCF_OFS_W + 2;
  localparam int unsigned CW = $clog2(DCF_STAGE_DEPTH + 1);
  localparam logic [SW-1:0] DEPTH_S = SW'(DEPTH);
  localparam logic [SW-1:0] HALF_S  = SW'(DEPTH / 2);
  localparam logic [CW-1:0] STG_MAX = CW'(DCF_STAGE_DEPTH);

  // per-depth default offset
  localparam logic [DCF_OFS_W-1:0] OFS_DEF =
    (DEPTH <= DCF_DEPTH_256) ? DCF_OFS_DEF_256 :
    (DEPTH <= DCF_DEPTH_512) ? DCF_OFS_DEF_512 : DCF_OFS_DEF_BIG;

  typedef struct packed
  {
    logic [PW-1:0]           wr_ptr;
    logic [PW-1:0]           fetch_ptr;
    logic                    inflight;
    logic [PW-1:0]           occ;
    logic [DCF_OFS_W-1:0]    empty_threshold_offset;
    logic [DCF_OFS_W-1:0]    full_threshold_offset;
    dcf_ofs_sel_e            wr_sel;
    dcf_ofs_sel_e            rd_sel;
    logic [DCF_DATA_W-1:0]   out_reg;
    logic                    oe;
    dcf_flags_s              flags;
    logic                    wchain;
    logic                    rchain;
  } dcf_main_st_s;

  dcf_main_st_s st;
  dcf_main_st_s next_st;

  // accepted requests and mode
  logic                  wr_acc;
  logic                  rd_acc;
  logic                  ofs_wr;
  logic                  ofs_rd;
  logic                  single_mode;

  // glue to storage and prefetch stage
  logic                  fetch;
  logic                  stg_room;
  logic [PW-1:0]         ram_words;
  logic [DCF_DATA_W-1:0] ram_rdata;
  logic                  stg_in_ready;
  logic                  stg_out_valid;
  logic [DCF_DATA_W-1:0] stg_out_data;
  logic [CW-1:0]         stg_count;
  logic [CW-1:0]         stg_next;

  // fill level and threshold terms
  logic [PW-1:0]         occ_next;
  logic [SW-1:0]         occ_s;
  logic [SW-1:0]         af_sum;
  logic [SW-1:0]         ae_lim;
  logic                  at_full;
  logic                  at_half;

  // RQ5 write accept
  // RQ6 full blocks writes
  assign wr_acc = !wr_port.en_n && offset_load_n && st.flags.full_n;
  // RQ13 offset write strobe
  // RQ15 disabled write ignored
  assign ofs_wr = !wr_port.en_n && !offset_load_n;

  // RQ8 read accept
  // RQ11 empty blocks reads
  assign rd_acc = !rd_port.en_n && offset_load_n && st.flags.empty_n && stg_out_valid;
  // RQ16 offset read strobe
  assign ofs_rd = !rd_port.en_n && !offset_load_n;

  // RQ24 mode from chain pins
  assign single_mode = !first_in_chain_n && !write_chain_in_n && !read_chain_in_n;

  // prefetch only when the stage has room for the word already in flight too;
  // this is the back-pressure that keeps the stage from overflowing
  assign ram_words = st.wr_ptr - st.fetch_ptr;
  assign stg_room  = (stg_count + CW'(st.inflight)) < STG_MAX;
  assign fetch     = (ram_words != '0) && stg_in_ready && stg_room;

  // stage fill after this cycle, used for the empty flag
  assign stg_next = stg_count + CW'(st.inflight) - CW'(rd_acc);

  // word count after this cycle
  assign occ_next = st.occ + PW'(wr_acc) - PW'(rd_acc);
  assign occ_s    = SW'(occ_next);

  // level tests on the count after this cycle; prefetched words still count,
  // so the thresholds agree with what the reader has not yet taken
  // RQ7 full level
  assign at_full = (occ_s == DEPTH_S);
  // RQ19 almost-full sum
  assign af_sum  = occ_s + SW'(st.full_threshold_offset);
  // RQ21 almost-empty limit
  assign ae_lim  = SW'(st.empty_threshold_offset);
  // RQ24 half level
  assign at_half = single_mode && (occ_s > HALF_S);

  // storage array
  dcf_ram #(
    .W  (DCF_DATA_W),
    .AW (AW)
  ) u_ram (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr_acc),
    .wr_addr (st.wr_ptr[AW-1:0]),
    .wr_data (wr_port.data),
    .rd_en   (fetch),
    .rd_addr (st.fetch_ptr[AW-1:0]),
    .rd_data (ram_rdata)
  );

  // prefetch stage feeding the output register
  dcf_stage_fifo #(
    .W     (DCF_DATA_W),
    .DEPTH (DCF_STAGE_DEPTH)
  ) u_stage (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (st.inflight),
    .in_ready  (stg_in_ready),
    .in_data   (ram_rdata),
    .out_valid (stg_out_valid),
    .out_ready (rd_acc),
    .out_data  (stg_out_data),
    .count     (stg_count)
  );

  // next state of pointers, offsets, output register and flags
  always_comb
  begin
    next_st = st;
    // one-cycle terms: fetch in flight, fill level, bus drive
    next_st.inflight = fetch;
    next_st.occ = occ_next;
    next_st.oe = !rd_port.oe_n;

    // RQ5 sequential store
    if (wr_acc)
    begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    // prefetch pointer moves with each storage read
    if (fetch)
    begin
      next_st.fetch_ptr = st.fetch_ptr + 1'b1;
    end

    // RQ13 offset write rotation
    // RQ14 sequence kept
    if (ofs_wr)
    begin
      if (st.wr_sel == DCF_SEL_EMPTY)
      begin
        next_st.empty_threshold_offset = wr_port.data[DCF_OFS_W-1:0];
        next_st.wr_sel = DCF_SEL_FULL;
      end
      else
      begin
        next_st.full_threshold_offset = wr_port.data[DCF_OFS_W-1:0];
        next_st.wr_sel = DCF_SEL_EMPTY;
      end
    end

    // RQ8 load next word
    // RQ9 hold otherwise
    if (rd_acc)
    begin
      next_st.out_reg = stg_out_data;
    end
    // RQ16 offset read rotation
    else if (ofs_rd)
    begin
      if (st.rd_sel == DCF_SEL_EMPTY)
      begin
        next_st.out_reg = {{(DCF_DATA_W-DCF_OFS_W){1'b0}}, st.empty_threshold_offset};
        next_st.rd_sel = DCF_SEL_FULL;
      end
      else
      begin
        next_st.out_reg = {{(DCF_DATA_W-DCF_OFS_W){1'b0}}, st.full_threshold_offset};
        next_st.rd_sel = DCF_SEL_EMPTY;
      end
    end

    // flags are registered, so each shows its level just after the edge that takes the request; empty_n rises two edges later
    // RQ7 full at depth
    next_st.flags.full_n = !at_full;
    // RQ11 empty tracks prefetched words
    next_st.flags.empty_n = (stg_next != '0);
    // RQ19 almost-full threshold
    // RQ20 moves on both edges
    next_st.flags.almost_full_n = !(af_sum >= DEPTH_S);
    // RQ21 almost-empty threshold
    // RQ22 moves on both edges
    next_st.flags.almost_empty_n = (occ_s > ae_lim);
    // RQ24 half-full in single mode
    next_st.flags.half_full_n = !at_half;
    // chain pulses are not generated; outputs rest high outside single mode
    next_st.wchain = single_mode ? next_st.flags.half_full_n : DCF_FLAG_HI;
    next_st.rchain = DCF_FLAG_HI;
  end

  // state register, synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      // RQ1 pointers to start
      st.wr_ptr <= '0;
      st.fetch_ptr <= '0;
      st.inflight <= DCF_FLAG_LO;
      st.occ <= '0;
      // RQ3 default offsets
      st.empty_threshold_offset <= OFS_DEF;
      st.full_threshold_offset <= OFS_DEF;
      // both offset sequences restart at the empty offset
      st.wr_sel <= DCF_SEL_EMPTY;
      st.rd_sel <= DCF_SEL_EMPTY;
      // RQ3 output cleared
      st.out_reg <= DCF_OUT_RST;
      st.oe <= DCF_FLAG_LO;
      // RQ2 reset flag levels
      st.flags <= DCF_FLAGS_RST;
      // chain pins rest high
      st.wchain <= DCF_FLAG_HI;
      st.rchain <= DCF_FLAG_HI;
    end
    else
    begin
      // RQ25 one clock, flags see pointers directly
      st <= next_st;
    end
  end

  // RQ12 bus drive enable
  assign read_data_oe      = st.oe;
  assign read_data         = st.out_reg;

  // flags and chain pins, each straight from its flop
  assign flags             = st.flags;
  assign write_chain_out_n = st.wchain;
  assign read_chain_out_n  = st.rchain;

endmodule : dcf_fifo
`default_nettype wire

// File: dcf_pkg.sv
// shared constants, enums and carriers of the dual-pointer fifo with programmable flags
package dcf_pkg;

  // word and offset widths
  localparam int unsigned DCF_DATA_W     = 18;
  localparam int unsigned DCF_OFS_W      = 12;

  // depth choices and default storage depth
  localparam int unsigned DCF_DEPTH_256  = 256;
  localparam int unsigned DCF_DEPTH_512  = 512;
  localparam int unsigned DCF_DEPTH_DEF  = 4096;

  // per-depth default threshold offsets
  localparam logic [11:0] DCF_OFS_DEF_256 = 12'h01f;
  localparam logic [11:0] DCF_OFS_DEF_512 = 12'h03f;
  localparam logic [11:0] DCF_OFS_DEF_BIG = 12'h07f;

  // prefetch stage between storage and output register
  localparam int unsigned DCF_STAGE_DEPTH = 4;

  // reset values
  localparam logic [17:0] DCF_OUT_RST    = 18'h00000;
  localparam logic        DCF_FLAG_HI    = 1'b1;
  localparam logic        DCF_FLAG_LO    = 1'b0;

  // offset register sequence; two states, one bit apart
  typedef enum logic
  {
    DCF_SEL_EMPTY = 1'b0,
    DCF_SEL_FULL  = 1'b1
  } dcf_ofs_sel_e;

  // writer side request
  typedef struct packed
  {
    logic        en_n;
    logic [17:0] data;
  } dcf_wr_port_s;

  // reader side request
  typedef struct packed
  {
    logic en_n;
    logic oe_n;
  } dcf_rd_port_s;

  // status flags, all active low
  typedef struct packed
  {
    logic full_n;
    logic almost_full_n;
    logic half_full_n;
    logic almost_empty_n;
    logic empty_n;
  } dcf_flags_s;

  // flag values driven during reset
  localparam dcf_flags_s DCF_FLAGS_RST = '{
    full_n:         DCF_FLAG_HI,
    almost_full_n:  DCF_FLAG_HI,
    half_full_n:    DCF_FLAG_HI,
    almost_empty_n: DCF_FLAG_LO,
    empty_n:        DCF_FLAG_LO
  };

endpackage : dcf_pkg

// File: dcf_ram.sv
// storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
module dcf_ram #(
  parameter int unsigned W  = 18,
  parameter int unsigned AW = 12
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  import dcf_pkg::*;

  typedef struct packed
  {
    logic [W-1:0] rdata;
  } dcf_ram_st_s;

  // the array stays outside the state struct so it maps onto block ram
  logic [W-1:0] mem [0:(1<<AW)-1];
  dcf_ram_st_s  st;
  dcf_ram_st_s  next_st;

  // read data updates only on a fetch
  always_comb
  begin
    next_st = st;
    if (rd_en)
    begin
      next_st.rdata = mem[rd_addr];
    end
  end

  // array write, no reset on the contents
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read word
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data = st.rdata;

endmodule : dcf_ram
`default_nettype wire

// File: dcf_stage_fifo.sv
// small valid/ready fifo that holds prefetched words
`timescale 1ns/1ps
`default_nettype none
module dcf_stage_fifo #(
  parameter int unsigned W     = 18,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // filling side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // draining side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic      [W-1:0]  out_data,
  // fill level
  output logic      [CW-1:0] count
);
  import dcf_pkg::*;

  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  typedef struct packed
  {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } dcf_stage_st_s;

  dcf_stage_st_s st;
  dcf_stage_st_s next_st;
  logic          push;
  logic          pop;

  // handshake terms from honest count
  assign in_ready  = (st.cnt != FULL_CNT);
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rp];
  assign count     = st.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointers wrap explicitly so depth need not be a power of two
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = (st.wp == LAST_IDX) ? '0 : st.wp + 1'b1;
    end
    if (pop)
    begin
      next_st.rp = (st.rp == LAST_IDX) ? '0 : st.rp + 1'b1;
    end
    if (push && !pop)
    begin
      next_st.cnt = st.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : dcf_stage_fifo
`default_nettype wire

// File: dcf_fifo_props.sv
// pin-level checks of the fifo top, bound into every instance
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_props #(
  parameter int unsigned DEPTH = 4096
) (
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  // requests
  input wire dcf_pkg::dcf_wr_port_s wr_port,
  input wire logic                  offset_load_n,
  input wire dcf_pkg::dcf_rd_port_s rd_port,
  // answers
  input wire logic [17:0]           read_data,
  input wire logic                  read_data_oe,
  input wire dcf_pkg::dcf_flags_s   flags,
  // mode pins
  input wire logic                  first_in_chain_n,
  input wire logic                  write_chain_in_n,
  input wire logic                  read_chain_in_n,
  // chain outputs
  input wire logic                  write_chain_out_n,
  input wire logic                  read_chain_out_n
);
  import dcf_pkg::*;
  logic        wr_ok;
  logic        rd_ok;
  logic [12:0] occ;
  logic [12:0] next_occ;
  // accepted data transfers; offset accesses leave the fill level alone
  assign wr_ok = !wr_port.en_n && offset_load_n && flags.full_n;
  assign rd_ok = !rd_port.en_n && offset_load_n && flags.empty_n;
  // words written but not yet delivered, prefetched ones included
  always_comb next_occ = occ + 13'(wr_ok) - 13'(rd_ok);
  always_ff @(posedge clk_sys) occ <= rst_n ? next_occ : 13'h0000;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // a write into an empty buffer, then a reader that keeps still
  sequence s_lone_write;
    occ == 13'h0000 && wr_ok;
  endsequence
  sequence s_reader_idle;
    rd_port.en_n [*4];
  endsequence
  a_reset_values: assert property (disable iff (1'b0) !rst_n |=>
    flags == DCF_FLAGS_RST && read_data == DCF_OUT_RST && !read_data_oe)
    else $error("reset values wrong");
  a_output_hold: assert property ((rd_port.en_n || (offset_load_n && !flags.empty_n))
    |=> $stable(read_data)) else $error("output changed without a read");
  a_full_holds: assert property (!flags.full_n && rd_port.en_n |=> !flags.full_n)
    else $error("full released without a read");
  a_full_count: assert property (flags.full_n == (occ != DEPTH))
    else $error("full flag disagrees with fill level");
  a_half_count: assert property (!first_in_chain_n && !write_chain_in_n &&
    !read_chain_in_n |-> flags.half_full_n == !(occ > DEPTH / 2))
    else $error("half flag disagrees with fill level");
  a_empty_none: assert property (occ == 13'h0000 |-> !flags.empty_n)
    else $error("empty flag high with nothing stored");
  a_first_word: assert property (s_lone_write ##1 s_reader_idle |-> flags.empty_n)
    else $error("written word never became readable");
  a_oe_delay: assert property ($past(rst_n) |-> read_data_oe == !$past(rd_port.oe_n))
    else $error("output enable does not follow its pin");
  a_offset_read: assert property (!offset_load_n && !rd_port.en_n |=>
    read_data[17:12] == 6'h00) else $error("offset readback upper bits set");
  a_chain_outs: assert property (write_chain_out_n == flags.half_full_n && read_chain_out_n)
    else $error("chain outputs disagree with half flag");
endmodule : dcf_fifo_props
bind dcf_fifo dcf_fifo_props #(.DEPTH(DEPTH)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .wr_port(wr_port), .offset_load_n(offset_load_n),
  .rd_port(rd_port), .read_data(read_data), .read_data_oe(read_data_oe), .flags(flags),
  .first_in_chain_n(first_in_chain_n), .write_chain_in_n(write_chain_in_n),
  .read_chain_in_n(read_chain_in_n), .write_chain_out_n(write_chain_out_n),
  .read_chain_out_n(read_chain_out_n));
`default_nettype wire

// File: dcf_agent.sv
// writer and reader controllers that drive the fifo's request pins
`timescale 1ns/1ps
`default_nettype none
module dcf_agent (
  // clock
  input  wire logic                 clk_sys,
  // status seen by the reader
  input  wire dcf_pkg::dcf_flags_s  flags,
  // requests
  output var dcf_pkg::dcf_wr_port_s wr_port,
  output var dcf_pkg::dcf_rd_port_s rd_port,
  output var logic                  offset_load_n
);
  import dcf_pkg::*;
  // idle levels; released data is inverted so stale words never look valid
  initial wr_port = '{en_n: 1'b1, data: 18'h3ffff};
  initial rd_port = '{en_n: 1'b1, oe_n: 1'b0};
  initial offset_load_n = 1'b1;
  task put(input logic [17:0] d, input logic ld_n, input logic en_n);
    @(posedge clk_sys);
    #1;
    offset_load_n = ld_n;
    wr_port = '{en_n: en_n, data: d};
    @(posedge clk_sys);
    #1;
    wr_port = '{en_n: 1'b1, data: ~d};
    offset_load_n = 1'b1;
  endtask : put
  // every word is asked for; waits a bounded time for data
  task take(input logic ld_n, input int tries, output logic ok);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (ld_n && flags.empty_n !== 1'b1 && n < tries)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    ok = (flags.empty_n === 1'b1) || !ld_n || tries == 0;
    rd_port.en_n = 1'b0;
    offset_load_n = ld_n;
    @(posedge clk_sys);
    #1;
    rd_port.en_n = 1'b1;
    offset_load_n = 1'b1;
  endtask : take
  task set_oe(input logic v);
    @(posedge clk_sys);
    #1;
    rd_port.oe_n = v;
  endtask : set_oe
endmodule : dcf_agent
`default_nettype wire

// File: dcf_fifo_tb.sv
// self-checking bench for the fifo top
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_tb;
  import dcf_pkg::*;
  localparam int unsigned DEPTH = 256;
  logic         clk_sys = 1'b0;
  logic         rst_n = 1'b0;
  dcf_wr_port_s wr_port;
  dcf_rd_port_s rd_port;
  logic         offset_load_n;
  logic [17:0]  read_data;
  logic         read_data_oe;
  dcf_flags_s   flags;
  logic         write_chain_out_n;
  logic         read_chain_out_n;
  logic         ok;
  int           failures = 0;
  int           comparisons = 0;
  int           i;
  // 200 MHz
  always #2.5 clk_sys = ~clk_sys;
  dcf_agent agent (.clk_sys(clk_sys), .flags(flags), .wr_port(wr_port),
    .rd_port(rd_port), .offset_load_n(offset_load_n));
  dcf_fifo #(.DEPTH(DEPTH)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .wr_port(wr_port),
    .offset_load_n(offset_load_n), .rd_port(rd_port), .read_data(read_data),
    .read_data_oe(read_data_oe), .flags(flags), .first_in_chain_n(1'b0),
    .write_chain_in_n(1'b0), .read_chain_in_n(1'b0),
    .write_chain_out_n(write_chain_out_n), .read_chain_out_n(read_chain_out_n));
  task check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  // a read that gives up after a bounded wait ends the run
  task rd(input logic ld_n);
    agent.take(ld_n, 40, ok);
    if (ok !== 1'b1)
    begin
      failures++;
      close_out();
    end
  endtask : rd
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    check("flags", flags, DCF_FLAGS_RST);
    check("read_data", read_data, 18'h00000);
    check("chain_out", {write_chain_out_n, read_chain_out_n}, 18'h00003);
    agent.take(1'b1, 0, ok);
    check("read_data", read_data, 18'h00000);
    rd(1'b0);
    check("empty ofs", read_data, {6'h00, DCF_OFS_DEF_256});
    rd(1'b0);
    check("full ofs", read_data, {6'h00, DCF_OFS_DEF_256});
    // offsets: empty 5, full 10, a no-op, then empty 3; upper bits zero
    agent.put(18'h00005, 1'b0, 1'b0);
    agent.put(18'h0000a, 1'b0, 1'b0);
    agent.put(18'h00fff, 1'b0, 1'b1);
    agent.put(18'h00003, 1'b0, 1'b0);
    rd(1'b0);
    check("empty ofs", read_data, 18'h00003);
    rd(1'b0);
    check("full ofs", read_data, 18'h0000a);
    // fill to the brim, watching every flag but empty at its boundary
    for (i = 1; i <= DEPTH; i++)
    begin
      agent.put(18'(i), 1'b1, 1'b0);
      if (i == 3 || i == 4) check("almost_empty_n", flags.almost_empty_n, i > 3);
      if (i == 128 || i == 129) check("half_full_n", flags.half_full_n, i < 129);
      if (i == 128 || i == 129) check("chain_out", write_chain_out_n, i < 129);
      if (i == 245 || i == 246) check("almost_full_n", flags.almost_full_n, i < 246);
      if (i == 255 || i == 256) check("full_n", flags.full_n, i < 256);
    end
    agent.put(18'h3ffff, 1'b1, 1'b0);
    check("full_n", flags.full_n, 1'b0);
    for (i = 1; i <= DEPTH; i++)
    begin
      rd(1'b1);
      check("word", read_data, 18'(i));
      if (i == 1) check("full_n", flags.full_n, 1'b1);
      if (i == 10 || i == 11) check("almost_full_n", flags.almost_full_n, i > 10);
      if (i == 127 || i == 128) check("half_full_n", flags.half_full_n, i > 127);
      if (i == 127 || i == 128) check("chain_out", write_chain_out_n, i > 127);
      if (i == 252 || i == 253) check("almost_empty_n", flags.almost_empty_n, i < 253);
    end
    agent.take(1'b1, 0, ok);
    check("read_data", read_data, 18'(DEPTH));
    check("empty_n", flags.empty_n, 1'b0);
    check("almost_empty_n", flags.almost_empty_n, 1'b0);
    agent.set_oe(1'b1);
    @(posedge clk_sys);
    #1;
    check("read_data_oe", read_data_oe, 1'b0);
    agent.set_oe(1'b0);
    @(posedge clk_sys);
    #1;
    check("read_data_oe", read_data_oe, 1'b1);
    // reset in mid-run with a word stored
    agent.put(18'h00111, 1'b1, 1'b0);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    check("flags", flags, DCF_FLAGS_RST);
    agent.put(18'h00333, 1'b1, 1'b0);
    rd(1'b1);
    check("word", read_data, 18'h00333);
    rd(1'b0);
    check("empty ofs", read_data, {6'h00, DCF_OFS_DEF_256});
    close_out();
  end
endmodule : dcf_fifo_tb
`default_nettype wire
